// ===== hw/wtu_pkg.sv
// Constants, register map and types of the watchdog timeout unit
// Overview of operation
// - After any reset the watchdog stays disabled; software sets control bit 7 to start.
// - Once enabled, writes cannot clear enable; only a reset disables the watchdog.
// - Period select bits [1:0] choose 2^27, 2^25, 2^22 or 2^18 counted cycles.
// - Clock select bits [4:3]: 00 system clock, 01 real-time clock, others reserved.
// - Every time-out sets the read-only reset-cause flag, bit 5, for either response.
// - Only a non-watchdog reset (chip or debug interface) clears the reset-cause flag.
// - Response bit 6: 0 resets the chip on time-out, 1 sends a nonmaskable interrupt.
// - Time-out outputs change only on a rising clock edge.
// - Writing A5h then 5Ah to the restart key reloads the counter and counting continues.
// - Second key byte may come any time later, but only counts before a time-out.
// - Restart key is 8-bit write-only, undefined at reset, never alters the control.
package wtu_pkg;
   // Register indexes; the byte address is four times the index
   localparam logic [9:0] IDX_CONTROL = 10'h093;
   localparam logic [9:0] IDX_RESTART_KEY = 10'h094;
   localparam logic [9:0] IDX_IRQ_STATUS = 10'h095;
   localparam logic [9:0] IDX_IRQ_MASK = 10'h096;
   localparam logic [11:0] ADDR_CONTROL = {IDX_CONTROL, 2'h0};
   localparam logic [11:0] ADDR_RESTART_KEY = {IDX_RESTART_KEY, 2'h0};
   localparam logic [11:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'h0};
   localparam logic [11:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'h0};

   localparam logic [7:0] KEY_FIRST = 8'hA5;
   localparam logic [7:0] KEY_SECOND = 8'h5A;

   localparam logic [1:0] CLK_SYSTEM = 2'h0;
   localparam logic [1:0] CLK_RTC = 2'h1;

   // Interrupt status bit positions
   localparam int unsigned STS_TIMEOUT = 0;
   localparam int unsigned STS_RESTART = 1;
   localparam int unsigned STS_KEY_ERR = 2;
   localparam int unsigned STS_W = 3;
   localparam logic [STS_W-1:0] STS_RESET = 3'h0;

   localparam logic [4:0] RST_PULSE_CYCLES = 5'h10;

   // Layout of the control register, bit 7 first
   typedef struct packed {
      logic en;
      logic nmi_sel;
      logic cause;
      logic [1:0] clk_sel;
      logic rsvd;
      logic [1:0] period;
   } wtu_ctl_s;

   localparam wtu_ctl_s CTL_RESET = wtu_ctl_s'(8'h00);
endpackage

// ===== hw/wtu_top.sv
// Watchdog timeout unit with APB register slave and interrupt logic
`timescale 1ns/1ps
`default_nettype none
module wtu_top #(
   parameter logic [27:0] PERIOD_SEL0_CYCLES = 28'h8000000,
   parameter logic [27:0] PERIOD_SEL1_CYCLES = 28'h2000000,
   parameter logic [27:0] PERIOD_SEL2_CYCLES = 28'h0400000,
   parameter logic [27:0] PERIOD_SEL3_CYCLES = 28'h0040000
) (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic debug_rst_i,
   input wire logic rtc_tick_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   output logic chip_reset_o,
   output logic nmi_o,
   output logic irq_o
);

   function automatic logic [27:0] period_len(input logic [1:0] sel);
      case (sel)
         2'h0: period_len = PERIOD_SEL0_CYCLES;
         2'h1: period_len = PERIOD_SEL1_CYCLES;
         2'h2: period_len = PERIOD_SEL2_CYCLES;
         default: period_len = PERIOD_SEL3_CYCLES;
      endcase
   endfunction

   wtu_pkg::wtu_ctl_s ctl_r;
   wtu_pkg::wtu_ctl_s ctl_nxt;
   wtu_pkg::wtu_ctl_s ctl_wdata;
   logic [27:0] cnt_r;
   logic [27:0] cnt_nxt;
   logic [4:0] hold_r;
   logic [4:0] hold_nxt;
   logic armed_r;
   logic armed_nxt;
   logic rtc_q_r;
   logic [wtu_pkg::STS_W-1:0] sts_r;
   logic [wtu_pkg::STS_W-1:0] sts_nxt;
   logic [wtu_pkg::STS_W-1:0] mask_r;
   logic [wtu_pkg::STS_W-1:0] sts_set;
   logic [wtu_pkg::STS_W-1:0] sts_clr;
   logic pready_r;
   logic pslverr_r;
   logic [31:0] prdata_r;
   logic chip_reset_r;
   logic nmi_r;
   logic irq_r;

   // Bus decode
   wire access = psel_i & penable_i;
   wire xfer = access & pready_r;
   wire pready_nxt = access & ~pready_r;
   wire sel_ctl = paddr_i == wtu_pkg::ADDR_CONTROL;
   wire sel_key = paddr_i == wtu_pkg::ADDR_RESTART_KEY;
   wire sel_sts = paddr_i == wtu_pkg::ADDR_IRQ_STATUS;
   wire sel_mask = paddr_i == wtu_pkg::ADDR_IRQ_MASK;
   wire addr_hit = sel_ctl | sel_key | sel_sts | sel_mask;
   wire wr_ok = xfer & pwrite_i & pstrb_i[0];
   wire wr_ctl = wr_ok & sel_ctl;
   wire wr_key = wr_ok & sel_key;
   wire wr_sts = wr_ok & sel_sts;
   wire wr_mask = wr_ok & sel_mask;
   wire [7:0] key_byte = pwdata_i[7:0];

   // Resets that do not come from the watchdog
   wire blk_rst = srst_i | debug_rst_i;
   wire in_hold = hold_r != 5'h00;

   // Counting source
   wire rtc_rise = rtc_tick_i & ~rtc_q_r;
   wire src_sys = ctl_r.clk_sel == wtu_pkg::CLK_SYSTEM;
   wire src_rtc = ctl_r.clk_sel == wtu_pkg::CLK_RTC;
   wire tick = ctl_r.en & (src_sys | (src_rtc & rtc_rise));
   wire expire = tick & (cnt_r == period_len(ctl_r.period) - 28'h1);
   wire reset_resp = expire & ~ctl_r.nmi_sel;
   wire nmi_resp = expire & ctl_r.nmi_sel;

   // Restart key sequence; a time-out in the same cycle wins
   wire key_first = wr_key & (key_byte == wtu_pkg::KEY_FIRST);
   wire key_done = wr_key & armed_r & (key_byte == wtu_pkg::KEY_SECOND);
   wire key_bad = wr_key & ~key_first & ~key_done;
   wire restart_hit = key_done & ~expire;

   assign ctl_wdata = wtu_pkg::wtu_ctl_s'(pwdata_i[7:0]);

   always_comb
   begin
      ctl_nxt = ctl_r;
      if (blk_rst)
      begin
         ctl_nxt = wtu_pkg::CTL_RESET;
      end
      else if (reset_resp)
      begin
         ctl_nxt = wtu_pkg::CTL_RESET;
         ctl_nxt.cause = 1'b1;
      end
      else
      begin
         if (wr_ctl & ~in_hold)
         begin
            ctl_nxt.en = ctl_r.en | ctl_wdata.en;
            ctl_nxt.nmi_sel = ctl_wdata.nmi_sel;
            ctl_nxt.clk_sel = ctl_wdata.clk_sel;
            ctl_nxt.period = ctl_wdata.period;
         end
         ctl_nxt.cause = ctl_r.cause | expire;
      end
   end

   // Counter is held at its initial count while disabled
   assign cnt_nxt = (blk_rst | ~ctl_r.en | expire | restart_hit) ? 28'h0 :
                    tick ? cnt_r + 28'h1 : cnt_r;

   assign armed_nxt = (blk_rst | expire) ? 1'b0 :
                      wr_key ? key_first : armed_r;

   assign hold_nxt = blk_rst ? 5'h00 :
                     reset_resp ? wtu_pkg::RST_PULSE_CYCLES :
                     in_hold ? hold_r - 5'h01 : 5'h00;

   // Interrupt status: set wins over a write-one clear
   assign sts_set = {key_bad, restart_hit, expire};
   assign sts_clr = wr_sts ? pwdata_i[wtu_pkg::STS_W-1:0] : wtu_pkg::STS_RESET;
   assign sts_nxt = blk_rst ? wtu_pkg::STS_RESET : (sts_r & ~sts_clr) | sts_set;

   wire [31:0] rd_mux = sel_ctl ? {24'h0, ctl_r} :
                        sel_sts ? {29'h0, sts_r} :
                        sel_mask ? {29'h0, mask_r} : 32'h0;

   always_ff @(posedge core_clk_i)
   begin
      ctl_r <= ctl_nxt;
      cnt_r <= cnt_nxt;
      armed_r <= armed_nxt;
      hold_r <= hold_nxt;
      sts_r <= sts_nxt;
   end

   // Time-out outputs registered on the rising edge
   always_ff @(posedge core_clk_i)
   begin
      if (blk_rst)
      begin
         chip_reset_r <= 1'b0;
         nmi_r <= 1'b0;
         // Follow the pin in reset so that no false edge follows release
         rtc_q_r <= rtc_tick_i;
      end
      else
      begin
         chip_reset_r <= hold_nxt != 5'h00;
         nmi_r <= nmi_resp;
         rtc_q_r <= rtc_tick_i;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (blk_rst)
      begin
         mask_r <= wtu_pkg::STS_RESET;
         irq_r <= 1'b0;
      end
      else
      begin
         if (wr_mask)
         begin
            mask_r <= pwdata_i[wtu_pkg::STS_W-1:0];
         end
         irq_r <= |(sts_r & mask_r);
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0;
      end
      else
      begin
         pready_r <= pready_nxt;
         pslverr_r <= pready_nxt & ~addr_hit;
         prdata_r <= (pready_nxt & ~pwrite_i) ? rd_mux : 32'h0;
      end
   end

   assign prdata_o = prdata_r;
   assign pready_o = pready_r;
   assign pslverr_o = pslverr_r;
   assign chip_reset_o = chip_reset_r;
   assign nmi_o = nmi_r;
   assign irq_o = irq_r;

   // Cycles that the current chip reset pulse has stood, for the length check
   logic [4:0] pulse_len_r;
   always_ff @(posedge core_clk_i)
   begin
      if (blk_rst | ~chip_reset_r)
      begin
         pulse_len_r <= 5'h00;
      end
      else
      begin
         pulse_len_r <= pulse_len_r + 5'h01;
      end
   end

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (srst_i);

   a_off_after_reset: assert property (
      $fell(srst_i) |-> !ctl_r.en && cnt_r == 28'h0)
      else $error("watchdog enabled right after reset");

   a_enable_sticky: assert property (
      ctl_r.en && !debug_rst_i && !reset_resp |=> ctl_r.en)
      else $error("enable cleared without a reset");

   a_expiry_count: assert property (
      expire |-> cnt_r == period_len(ctl_r.period) - 28'h1)
      else $error("expiry at wrong count");

   a_rtc_gating: assert property (
      ctl_r.en && src_rtc && !rtc_rise && !restart_hit && !debug_rst_i |=> $stable(cnt_r))
      else $error("counter moved without rtc edge");

   a_reserved_clk: assert property (
      ctl_r.en && !src_sys && !src_rtc |-> !expire)
      else $error("reserved clock source counted");

   a_cause_set: assert property (
      expire && !debug_rst_i |=> ctl_r.cause)
      else $error("reset cause not set on time-out");

   a_cause_clear: assert property (
      debug_rst_i |=> !ctl_r.cause)
      else $error("reset cause kept after debug reset");

   a_cause_kept: assert property (
      ctl_r.cause && !debug_rst_i |=> ctl_r.cause)
      else $error("reset cause lost without reset");

   a_reset_pulse: assert property (
      reset_resp && !debug_rst_i |=> chip_reset_o [*8] ##1 !nmi_o)
      else $error("chip reset pulse too short");

   a_nmi_pulse: assert property (
      nmi_resp && !debug_rst_i |=> nmi_o && !chip_reset_o ##1 !nmi_o)
      else $error("nmi not a single pulse");

   a_nmi_cause: assert property (
      $rose(nmi_o) |-> $past(expire) && ctl_r.cause)
      else $error("nmi without time-out");

   a_restart_reload: assert property (
      restart_hit && !debug_rst_i |=> cnt_r == 28'h0 && ctl_r.en == $past(ctl_r.en))
      else $error("restart did not reload counter");

   a_key_keeps_ctl: assert property (
      wr_key && !expire && !debug_rst_i |=> $stable(ctl_r))
      else $error("key write altered control");

   a_key_discard: assert property (
      key_bad |=> !armed_r ##0 $stable(sts_r[wtu_pkg::STS_TIMEOUT]) || $past(expire))
      else $error("bad key byte kept sequence");

   a_hold_initial: assert property (
      !ctl_r.en |-> cnt_r == 28'h0)
      else $error("disabled counter moved");

   a_count_step: assert property (
      tick && !expire && !restart_hit && !debug_rst_i |=> cnt_r == $past(cnt_r) + 28'h1)
      else $error("counter did not advance by one");

   a_enable_by_write: assert property (
      !ctl_r.en && !wr_ctl |=> !ctl_r.en)
      else $error("watchdog enabled without a control write");

   a_key_arms: assert property (
      key_first && !expire && !debug_rst_i |=> armed_r)
      else $error("first key byte did not arm restart");

   a_timeout_disarms: assert property (
      expire |=> !armed_r)
      else $error("restart sequence survived a time-out");

   a_reset_resp_ctl: assert property (
      reset_resp && !debug_rst_i |=> !ctl_r.en && ctl_r.cause)
      else $error("reset response left watchdog running");

   a_nmi_keeps_run: assert property (
      nmi_resp && !debug_rst_i |=> ctl_r.en && cnt_r == 28'h0)
      else $error("nmi response stopped the watchdog");

   a_one_response: assert property (
      !(chip_reset_o && nmi_o))
      else $error("reset and nmi raised together");

   a_pulse_length: assert property (
      $fell(chip_reset_o) && pulse_len_r != 5'h00 |-> pulse_len_r == wtu_pkg::RST_PULSE_CYCLES)
      else $error("chip reset pulse of wrong length");

   a_cause_readonly: assert property (
      wr_ctl && !expire && !debug_rst_i |=> ctl_r.cause == $past(ctl_r.cause))
      else $error("control write changed reset cause");

   a_key_reads_zero: assert property (
      pready_o && !pwrite_i && sel_key |-> prdata_o == 32'h0)
      else $error("restart key read back non-zero");

   a_ready_one_wait: assert property (
      access && !pready_o |=> pready_o)
      else $error("bus answer not after one wait state");

   a_ready_pulse: assert property (
      pready_o |=> !pready_o)
      else $error("bus ready stood more than one cycle");

   a_err_unmapped: assert property (
      pready_o |-> pslverr_o == !addr_hit)
      else $error("bus error flag wrong for address");

   c_timeout_reset: cover property (reset_resp ##1 chip_reset_o);
   c_timeout_nmi: cover property (nmi_resp ##1 nmi_o);
   c_restart_done: cover property (key_first ##[1:20] restart_hit);
   c_key_error: cover property (key_first ##[1:20] key_bad);
   c_rtc_expire: cover property (src_rtc && expire);

endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the watchdog timeout unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam logic [11:0] AC = wtu_pkg::ADDR_CONTROL;
   localparam logic [11:0] AK = wtu_pkg::ADDR_RESTART_KEY;
   localparam logic [11:0] AS = wtu_pkg::ADDR_IRQ_STATUS;
   localparam logic [11:0] AM = wtu_pkg::ADDR_IRQ_MASK;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic drst = 1'b0;
   logic rtc = 1'b0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [11:0] pa = 12'h000;
   logic [31:0] pwd = 32'h0;
   logic [31:0] prd;
   logic prdy, perr, crst, nmi, irq, err;
   logic [7:0] rcnt, ncnt, rd, b, r0;
   logic [31:0] seed = 32'hB40FA5BA;
   int fail_count = 0;
   int compares = 0;
   int c;
   wtu_top #(.PERIOD_SEL0_CYCLES(28'h40), .PERIOD_SEL1_CYCLES(28'h20),
      .PERIOD_SEL2_CYCLES(28'h10), .PERIOD_SEL3_CYCLES(28'h8)) wtu_top_inst (
      .core_clk_i(clk), .srst_i(srst), .debug_rst_i(drst), .rtc_tick_i(rtc),
      .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
      .pstrb_i(4'hF), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
      .chip_reset_o(crst), .nmi_o(nmi), .irq_o(irq));
   wtu_cpu_model wtu_cpu_model_inst (.core_clk_i(clk), .chip_reset_i(crst),
      .nmi_i(nmi), .rst_cnt_o(rcnt), .nmi_cnt_o(ncnt));
   initial
      forever #5 clk = ~clk;
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic stop_test();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      pa <= a;
      pwd <= {24'h0, d};
      @(posedge clk);
      pen <= 1'b1;
      do
      begin
         @(posedge clk);
      end
      while (prdy !== 1'b1);
      rd = prd[7:0];
      err = perr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rst(input int n);
      srst <= 1'b1;
      repeat (n) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
   endtask
   // Cycles until a time-out output shows, bounded by lim
   task automatic wait_to(input int lim);
      c = 0;
      while (!(crst === 1'b1 || nmi === 1'b1) && c < lim)
      begin
         @(posedge clk);
         c++;
      end
   endtask
   initial
   begin
      repeat (50000) @(posedge clk);
      fail_count++;
      stop_test();
   end
   initial
   begin
      rst(16);
      apb(0, AC, 0);
      chk("ctl", 8'h00, rd);
      apb(0, AK, 0);
      chk("key", 8'h00, rd);
      apb(0, 12'h000, 0);
      chk("slverr", 1, err);
      apb(1, AC, 8'hC3);
      wait_to(40);
      @(posedge clk);
      chk("nmi", 1, ncnt);
      chk("rst", 0, rcnt);
      apb(1, AC, 8'h43);
      apb(0, AC, 0);
      chk("ctl", 8'hE3, rd);
      rst(2);
      apb(0, AC, 0);
      chk("ctl", 8'h00, rd);
      apb(1, AM, 8'h07);
      apb(1, AC, 8'h80);
      repeat (4)
      begin
         repeat (rnd() % 16) @(posedge clk);
         apb(1, AK, 8'hA5);
         repeat (rnd() % 16) @(posedge clk);
         apb(1, AK, 8'h5A);
      end
      chk("rst", 0, rcnt);
      apb(0, AS, 0);
      chk("sts", 8'h02, rd);
      chk("irq", 1, irq);
      apb(1, AS, 8'h02);
      @(posedge clk);
      chk("irq", 0, irq);
      b = 8'(rnd());
      if (b == 8'h5A || b == 8'hA5)
         b = 8'h00;
      apb(1, AK, 8'hA5);
      apb(1, AK, b);
      apb(1, AK, 8'h5A);
      wait_to(80);
      chk("noreload", 1, c < 56 && crst === 1'b1);
      repeat (20) @(posedge clk);
      apb(0, AC, 0);
      chk("ctl", 8'h20, rd);
      apb(0, AS, 0);
      chk("sts", 8'h05, rd);
      drst <= 1'b1;
      @(posedge clk);
      drst <= 1'b0;
      @(posedge clk);
      apb(0, AC, 0);
      chk("ctl", 8'h00, rd);
      for (int p = 0; p < 4; p++)
      begin
         rst(2);
         repeat (70) @(posedge clk);
         apb(1, AC, 8'h80 | p[7:0]);
         wait_to(200);
         chk("period", 32'(64 >> p), c);
      end
      rst(2);
      r0 = rcnt;
      apb(1, AC, 8'h8B);
      wait_to(60);
      chk("rtc_idle", 60, c);
      repeat (20)
      begin
         rtc <= ~rtc;
         repeat (rnd() % 3 + 2) @(posedge clk);
      end
      chk("rtc_to", r0 + 8'h01, rcnt);
      rst(2);
      apb(1, AC, 8'h93);
      wait_to(100);
      chk("rsvd_clk", 100, c);
      stop_test();
   end
endmodule
`default_nettype wire

// ===== tb/wtu_cpu_model.sv
// CPU core model counting watchdog reset and NMI requests
`timescale 1ns/1ps
`default_nettype none
module wtu_cpu_model (
   input wire logic core_clk_i,
   input wire logic chip_reset_i,
   input wire logic nmi_i,
   output logic [7:0] rst_cnt_o,
   output logic [7:0] nmi_cnt_o
);
   logic rst_q = 1'b0;
   logic [7:0] rst_cnt_r = 8'h00;
   logic [7:0] nmi_cnt_r = 8'h00;
   assign rst_cnt_o = rst_cnt_r;
   assign nmi_cnt_o = nmi_cnt_r;
   // Reset requests are seen only at rising edges; an NMI counts in every cycle it is high
   always @(posedge core_clk_i)
   begin
      rst_q <= chip_reset_i;
      if (chip_reset_i && !rst_q)
         rst_cnt_r <= rst_cnt_r + 8'h01;
      if (nmi_i)
         nmi_cnt_r <= nmi_cnt_r + 8'h01;
   end
endmodule
`default_nettype wire
